// *** common/tmb_pkg.sv ***
// Purpose: shared constants and types of the 16-bit timer with byte access
// Assumes: one 200 MHz clock, AHB-Lite register bus, one 8-bit register per word
// Notes: byte address of a register is four times its index

package tmb_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned MODE_W = 4;

  // ************************************************************
  // register indices (byte address = 4 * index)
  // ************************************************************
  localparam logic [IDX_W-1:0] REG_CNT_LO = 4'h0;
  localparam logic [IDX_W-1:0] REG_CNT_HI = 4'h1;
  localparam logic [IDX_W-1:0] REG_CMPA_LO = 4'h2;
  localparam logic [IDX_W-1:0] REG_CMPA_HI = 4'h3;
  localparam logic [IDX_W-1:0] REG_CMPB_LO = 4'h4;
  localparam logic [IDX_W-1:0] REG_CMPB_HI = 4'h5;
  localparam logic [IDX_W-1:0] REG_CAP_LO = 4'h6;
  localparam logic [IDX_W-1:0] REG_CAP_HI = 4'h7;
  localparam logic [IDX_W-1:0] REG_CTRL = 4'h8;
  localparam logic [IDX_W-1:0] REG_FLAGS = 4'h9;
  localparam logic [IDX_W-1:0] REG_STATUS = 4'ha;

  // ************************************************************
  // control and flag fields, reset values
  // ************************************************************
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_RUN = 4;
  localparam int unsigned CTL_FILT = 5;
  localparam int unsigned CTL_EDGE = 6;
  localparam int unsigned CTL_SRC = 7;
  localparam int unsigned FLG_CMPA = 0;
  localparam int unsigned FLG_CMPB = 1;
  localparam int unsigned FLG_CAP = 2;
  localparam int unsigned FLG_W = 3;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ************************************************************
  // count limits
  // ************************************************************
  localparam logic [CNT_W-1:0] CNT_FLOOR = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
  localparam logic [CNT_W-1:0] CEIL_8B = 16'h00ff;
  localparam logic [CNT_W-1:0] CEIL_9B = 16'h01ff;
  localparam logic [CNT_W-1:0] CEIL_10B = 16'h03ff;

  // ************************************************************
  // bus encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // where the ceiling of the count sequence comes from
  typedef enum logic [2:0] {
    CEIL_SRC_FULL = 3'h0,
    CEIL_SRC_8B = 3'h1,
    CEIL_SRC_9B = 3'h2,
    CEIL_SRC_10B = 3'h3,
    CEIL_SRC_CMPA = 3'h4,
    CEIL_SRC_CAP = 3'h5
  } tmb_ceil_e;

  // one byte access from the bus slave to the timer core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [IDX_W-1:0] idx;
    logic [BYTE_W-1:0] wdata;
  } tmb_acc_s;

endpackage : tmb_pkg

// *** rtl/tmb_ahb_slave.sv ***
// Purpose: AHB-Lite slave turning word transfers into byte strobes
// Assumes: single word transfers, one slave on the bus
// Notes: writes take no wait state, reads take one

`timescale 1ns/100ps

module tmb_ahb_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // byte access to the core
  output tmb_pkg::tmb_acc_s acc,
  input wire logic [tmb_pkg::BYTE_W-1:0] acc_rdata
);
  import tmb_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WR = 4'h2,
    ST_RD = 4'h4,
    ST_RDONE = 4'h8
  } tmb_bus_e;

  tmb_bus_e st_r, st_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic map_r, map_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic take;
  logic hit;

  // ************************************************************
  // address phase decode
  // ************************************************************
  assign take = hsel && htrans == HTRANS_NONSEQ && hready;
  assign hit = haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0 && haddr[5:2] <= REG_STATUS;

  // next state; a wait state holds a read so its side effects land once
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    map_nxt = map_r;
    rd_nxt = rd_r;
    if (st_r == ST_RD) begin
      st_nxt = ST_RDONE;
      rd_nxt = map_r ? {24'h0, acc_rdata} : 32'h0;
    end else if (take) begin
      st_nxt = hwrite ? ST_WR : ST_RD;
      idx_nxt = haddr[5:2];
      map_nxt = hit;
    end else begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_IDLE;
      idx_r <= REG_CNT_LO;
      map_r <= 1'b0;
      rd_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      map_r <= map_nxt;
      rd_r <= rd_nxt;
    end
  end

  // each 16-bit value moves as separate byte accesses
  assign acc.wr = st_r == ST_WR && map_r;
  assign acc.rd = st_r == ST_RD && map_r;
  assign acc.idx = idx_r;
  assign acc.wdata = hwdata[BYTE_W-1:0];
  assign hreadyout = st_r != ST_RD;
  assign hrdata = rd_r;
  assign hresp = HRESP_OKAY;

endmodule : tmb_ahb_slave

// *** rtl/tmb_cap_filter.sv ***
// Purpose: capture source select, noise filter and edge detect
// Assumes: inputs synchronous to hclk
// Notes: with the filter on, a level must hold FILT_LEN samples

`timescale 1ns/100ps

module tmb_cap_filter #(
  parameter int unsigned FILT_LEN = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // event sources
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  // setup
  input wire logic src_cmp,
  input wire logic filt_en,
  input wire logic edge_rise,
  // result
  output logic cap_evt
);
  import tmb_pkg::*;

  logic [FILT_LEN-1:0] samp_r, samp_nxt;
  logic lvl_r, lvl_nxt;
  logic evt_r, evt_nxt;
  logic raw;

  // filter holds the old level until every sample agrees
  always_comb begin
    raw = src_cmp ? comparator_out : capture_input_pin;
    samp_nxt = {samp_r[FILT_LEN-2:0], raw};
    lvl_nxt = raw;
    if (filt_en) begin
      lvl_nxt = (&samp_nxt) ? 1'b1 : ((|samp_nxt) ? lvl_r : 1'b0);
    end
    evt_nxt = edge_rise ? (lvl_nxt && !lvl_r) : (!lvl_nxt && lvl_r);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_r <= '0;
      lvl_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      samp_r <= samp_nxt;
      lvl_r <= lvl_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign cap_evt = evt_r;

  property p_filt_rise;
    @(posedge hclk) disable iff (!hresetn)
    filt_en && $past(filt_en) && $rose(lvl_r) |-> &samp_r;
  endproperty
  a_filt_rise: assert property (p_filt_rise) else $error("filter passed a short pulse");

endmodule : tmb_cap_filter

// *** rtl/tmb_timer16.sv ***
// Purpose: 16-bit timer core with byte-wide access through a shared high-byte hold
// Assumes: counts once per clock when run is set; no prescaler
// Notes: register map over AHB-Lite, one byte per aligned word

`timescale 1ns/100ps

module tmb_timer16 #(
  parameter int unsigned FILT_LEN = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // capture sources and service
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic capture_irq_ack,
  // flags, limits and waves
  output logic [1:0] compare_match_flags,
  output logic capture_event_flag,
  output logic count_floor,
  output logic count_full,
  output logic count_ceiling,
  output logic wave_a,
  output logic wave_b
);
  import tmb_pkg::*;

  tmb_acc_s acc;
  logic [BYTE_W-1:0] rdata;
  logic cap_evt;

  logic [CNT_W-1:0] count_value_r, count_value_nxt;
  logic [CNT_W-1:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
  logic [CNT_W-1:0] compare_value_a_r, compare_value_a_nxt;
  logic [CNT_W-1:0] compare_value_b_r, compare_value_b_nxt;
  logic [CNT_W-1:0] capture_value_r, capture_value_nxt;
  logic [BYTE_W-1:0] hold_r, hold_nxt, ctrl_r, ctrl_nxt;
  logic [FLG_W-1:0] flag_r, flag_nxt;
  logic wave_a_r, wave_a_nxt, wave_b_r, wave_b_nxt;

  logic [MODE_W-1:0] waveform_mode_select;
  tmb_ceil_e ceil_src;
  logic [CNT_W-1:0] ceil_val;
  logic tick, at_ceil, pwm_mode, cap_ceil_mode, take_cap;
  logic wr_cnt, wr_cap;

  // ************************************************************
  // bus slave and capture front end
  // ************************************************************
  tmb_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .acc(acc),
    .acc_rdata(rdata)
  );

  tmb_cap_filter #(.FILT_LEN(FILT_LEN)) u_cap (
    .hclk(hclk),
    .hresetn(hresetn),
    .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out),
    .src_cmp(ctrl_r[CTL_SRC]),
    .filt_en(ctrl_r[CTL_FILT]),
    .edge_rise(ctrl_r[CTL_EDGE]),
    .cap_evt(cap_evt)
  );

  // ************************************************************
  // mode decode and ceiling
  // ************************************************************
  assign waveform_mode_select = ctrl_r[CTL_MODE_LSB +: MODE_W];

  // mode picks the ceiling source
  always_comb begin
    unique case (waveform_mode_select)
      4'h1, 4'h5: ceil_src = CEIL_SRC_8B;
      4'h2, 4'h6: ceil_src = CEIL_SRC_9B;
      4'h3, 4'h7: ceil_src = CEIL_SRC_10B;
      4'h4, 4'h9, 4'hb, 4'hf: ceil_src = CEIL_SRC_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: ceil_src = CEIL_SRC_CAP;
      default: ceil_src = CEIL_SRC_FULL;
    endcase
    unique case (ceil_src)
      CEIL_SRC_8B: ceil_val = CEIL_8B;
      CEIL_SRC_9B: ceil_val = CEIL_9B;
      CEIL_SRC_10B: ceil_val = CEIL_10B;
      CEIL_SRC_CMPA: ceil_val = compare_value_a_r;
      CEIL_SRC_CAP: ceil_val = capture_value_r;
      default: ceil_val = CNT_FULL;
    endcase
  end

  // modes 0, 4 and c (full, compare A and capture ceilings) update compares at once
  assign pwm_mode = waveform_mode_select != 4'h0 && waveform_mode_select != 4'h4
    && waveform_mode_select != 4'hc;
  assign cap_ceil_mode = ceil_src == CEIL_SRC_CAP;
  assign tick = ctrl_r[CTL_RUN];
  assign at_ceil = count_value_r == ceil_val;
  assign wr_cnt = acc.wr && acc.idx == REG_CNT_LO;
  assign wr_cap = acc.wr && acc.idx == REG_CAP_LO && cap_ceil_mode;
  // capture hardware is idle while its register sets the ceiling
  assign take_cap = cap_evt && !cap_ceil_mode;

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    unique case (acc.idx)
      REG_CNT_LO: rdata = count_value_r[BYTE_W-1:0];
      REG_CNT_HI, REG_CAP_HI: rdata = hold_r;
      REG_CMPA_LO: rdata = buf_a_r[BYTE_W-1:0];
      REG_CMPA_HI: rdata = buf_a_r[CNT_W-1:BYTE_W];
      REG_CMPB_LO: rdata = buf_b_r[BYTE_W-1:0];
      REG_CMPB_HI: rdata = buf_b_r[CNT_W-1:BYTE_W];
      REG_CAP_LO: rdata = capture_value_r[BYTE_W-1:0];
      REG_CTRL: rdata = ctrl_r;
      REG_FLAGS: rdata = {{(BYTE_W-FLG_W){1'b0}}, flag_r};
      REG_STATUS: rdata = {5'h0, count_ceiling, count_full, count_floor};
      default: rdata = BYTE_RST;
    endcase
  end

  // ************************************************************
  // register file, counter and flags
  // ************************************************************
  always_comb begin
    hold_nxt = hold_r;
    ctrl_nxt = ctrl_r;
    buf_a_nxt = buf_a_r;
    buf_b_nxt = buf_b_r;
    capture_value_nxt = capture_value_r;
    flag_nxt = flag_r;
    count_value_nxt = count_value_r;
    // one hold shared by all high bytes
    if (acc.wr && acc.idx[0] && acc.idx < REG_CTRL) begin
      hold_nxt = acc.wdata;
    end
    // low read snapshots the high byte
    if (acc.rd && acc.idx == REG_CNT_LO) begin
      hold_nxt = count_value_r[CNT_W-1:BYTE_W];
    end
    if (acc.rd && acc.idx == REG_CAP_LO) begin
      hold_nxt = capture_value_r[CNT_W-1:BYTE_W];
    end
    if (acc.wr && acc.idx == REG_CTRL) begin
      ctrl_nxt = acc.wdata;
    end
    // low write joins hold and byte in one cycle
    if (acc.wr && acc.idx == REG_CMPA_LO) begin
      buf_a_nxt = {hold_r, acc.wdata};
    end
    if (acc.wr && acc.idx == REG_CMPB_LO) begin
      buf_b_nxt = {hold_r, acc.wdata};
    end
    // counter wraps at the ceiling to the floor
    if (tick) begin
      count_value_nxt = at_ceil ? CNT_FLOOR : count_value_r + 16'h0001;
    end
    // cpu write overrides count and clear
    if (wr_cnt) begin
      count_value_nxt = {hold_r, acc.wdata};
    end
    if (wr_cap) begin
      capture_value_nxt = {hold_r, acc.wdata};
    end
    if (take_cap) begin
      capture_value_nxt = count_value_r;
    end
    // write-one clears, ack clears capture; a set in the same cycle wins
    if (acc.wr && acc.idx == REG_FLAGS) begin
      flag_nxt = flag_r & ~acc.wdata[FLG_W-1:0];
    end
    if (capture_irq_ack) begin
      flag_nxt[FLG_CAP] = 1'b0;
    end
    if (tick && count_value_r == compare_value_a_r) begin
      flag_nxt[FLG_CMPA] = 1'b1;
    end
    if (tick && count_value_r == compare_value_b_r) begin
      flag_nxt[FLG_CMPB] = 1'b1;
    end
    if (take_cap) begin
      flag_nxt[FLG_CAP] = 1'b1;
    end
  end

  // pwm modes take new compares only at the ceiling
  always_comb begin
    compare_value_a_nxt = compare_value_a_r;
    compare_value_b_nxt = compare_value_b_r;
    if (!pwm_mode || (tick && at_ceil)) begin
      compare_value_a_nxt = buf_a_nxt;
      compare_value_b_nxt = buf_b_nxt;
    end
    // compare A as ceiling drives no pwm
    wave_a_nxt = ceil_src != CEIL_SRC_CMPA && count_value_nxt < compare_value_a_nxt;
    wave_b_nxt = count_value_nxt < compare_value_b_nxt;
  end

  // all values, hold and flags clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value_r <= CNT_RST;
      buf_a_r <= CNT_RST;
      buf_b_r <= CNT_RST;
      compare_value_a_r <= CNT_RST;
      compare_value_b_r <= CNT_RST;
      capture_value_r <= CNT_RST;
      hold_r <= BYTE_RST;
      ctrl_r <= BYTE_RST;
      flag_r <= '0;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      buf_a_r <= buf_a_nxt;
      buf_b_r <= buf_b_nxt;
      compare_value_a_r <= compare_value_a_nxt;
      compare_value_b_r <= compare_value_b_nxt;
      capture_value_r <= capture_value_nxt;
      hold_r <= hold_nxt;
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
    end
  end

  // limit indications follow the counter
  assign count_floor = count_value_r == CNT_FLOOR;
  assign count_full = count_value_r == CNT_FULL;
  assign count_ceiling = at_ceil;
  assign compare_match_flags = flag_r[FLG_CMPB:FLG_CMPA];
  assign capture_event_flag = flag_r[FLG_CAP];
  assign wave_a = wave_a_r;
  assign wave_b = wave_b_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hi_wr;
    acc.wr && acc.idx == REG_CNT_HI;
  endsequence
  sequence s_lo_wr;
    acc.wr && acc.idx == REG_CNT_LO;
  endsequence

  property p_cmp_flag;
    tick && count_value_r == compare_value_a_r |=> compare_match_flags[0];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare A flag missed");

  property p_capture;
    take_cap |=> capture_value_r == $past(count_value_r) && capture_event_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_wrap;
    tick && at_ceil && !wr_cnt |=> count_floor;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at ceiling");

  property p_dbl_buf;
    pwm_mode && !(tick && at_ceil) |=> $stable(compare_value_a_r);
  endproperty
  a_dbl_buf: assert property (p_dbl_buf) else $error("compare A changed mid-period");

  property p_no_pwm_a;
    ceil_src == CEIL_SRC_CMPA ##1 ceil_src == CEIL_SRC_CMPA |-> !wave_a;
  endproperty
  a_no_pwm_a: assert property (p_no_pwm_a) else $error("pwm on ceiling channel");

  property p_full_wrap;
    count_full && tick && ceil_src == CEIL_SRC_FULL && !wr_cnt |=> count_floor;
  endproperty
  a_full_wrap: assert property (p_full_wrap) else $error("no floor after full");

  property p_atomic;
    s_hi_wr ##1 !acc.wr ##1 s_lo_wr
      |=> count_value_r == {$past(acc.wdata, 3), $past(acc.wdata)};
  endproperty
  a_atomic: assert property (p_atomic) else $error("16-bit write torn");

  property p_cnt_wr;
    wr_cnt |=> count_value_r == {$past(hold_r), $past(acc.wdata)};
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");

  property p_rd_snap;
    acc.rd && acc.idx == REG_CNT_LO |=> hold_r == $past(count_value_r[CNT_W-1:BYTE_W]);
  endproperty
  a_rd_snap: assert property (p_rd_snap) else $error("hold not loaded");

  property p_cmp_rd;
    acc.rd && acc.idx == REG_CMPA_HI |-> rdata == buf_a_r[CNT_W-1:BYTE_W] ##1 $stable(hold_r);
  endproperty
  a_cmp_rd: assert property (p_cmp_rd) else $error("compare read used hold");

  property p_cap_lock;
    acc.wr && acc.idx == REG_CAP_LO && !cap_ceil_mode && !take_cap |=> $stable(capture_value_r);
  endproperty
  a_cap_lock: assert property (p_cap_lock) else $error("capture written in wrong mode");

  property p_ack;
    capture_irq_ack && !take_cap |=> !capture_event_flag;
  endproperty
  a_ack: assert property (p_ack) else $error("capture flag not cleared");

endmodule : tmb_timer16

// *** verification/tmb_cpu_model.sv ***
// Purpose: processor-side bus master model for the byte-wide timer
// Assumes: one master, single word transfers, one byte used per word
// Notes: waits on hready with no cycle count; the bench bounds the run
`timescale 1ns/100ps

module tmb_cpu_model (
  // clock
  input wire logic hclk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // read results for the bench
  output logic [7:0] rd_byte,
  output logic [15:0] rd_cnt
);
  import tmb_pkg::*;
  logic [7:0] smp;

  // idle bus from time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_cnt = 16'h0;
  end

  // hready and read data are taken at the rising edge, before that edge's updates land
  task automatic wait_rdy();
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    smp = hrdata[7:0];
  endtask : wait_rdy

  // one access at a time, so nothing can split a two-byte pair
  task automatic xfer(input logic [3:0] idx, input logic wr, input logic [7:0] d);
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    hwdata <= ~{24'h0, d}; // released data bus must not keep a stale value
    if (!wr) begin
      rd_byte = smp;
      rd_cnt = rd_cnt + 16'h1;
    end
  endtask : xfer
endmodule : tmb_cpu_model

// *** verification/test_timer16_byte_access.sv ***
// Purpose: self-checking bench of the byte-access timer
// Assumes: write lands at end of data phase, capture filter of 4 samples
// Notes: reads are queued with their expected byte and checked by a monitor
`timescale 1ns/100ps

module test_timer16_byte_access;
  import tmb_pkg::*;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic capture_input_pin, comparator_out, capture_irq_ack;
  logic [1:0] compare_match_flags;
  logic capture_event_flag, count_floor, count_full, count_ceiling, wave_a, wave_b;
  logic [7:0] rd_byte;
  logic [15:0] rd_cnt, v;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int seed = 70;
  logic [3:0] lo_t [3] = '{REG_CNT_LO, REG_CMPA_LO, REG_CMPB_LO};
  logic [3:0] mode_t [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h5, 4'hd, 4'hc};
  logic [15:0] ceil_t [9] = '{CNT_FULL, CEIL_8B, CEIL_9B, CEIL_10B, 16'h5a3c, 16'habcd,
    CEIL_8B, CNT_FULL, 16'habcd};

  tmb_timer16 #(.FILT_LEN(4)) tmb_timer16_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .capture_input_pin, .comparator_out, .capture_irq_ack, .compare_match_flags,
    .capture_event_flag, .count_floor, .count_full, .count_ceiling, .wave_a, .wave_b);
  tmb_cpu_model tmb_cpu_model_inst (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .rd_byte, .rd_cnt);

  // 200 mhz clock
  always #2.5 hclk = ~hclk;

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    tmb_cpu_model_inst.xfer(i, 1'b1, d);
  endtask : wr

  // high byte first so the hold is loaded before the low byte commits
  task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
    wr(lo + 4'h1, d[15:8]);
    wr(lo, d[7:0]);
  endtask : wr16

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    tmb_cpu_model_inst.xfer(i, 1'b0, 8'h00);
  endtask : rd

  // low byte first, so a count or capture high byte comes from the hold
  task automatic rd16(input logic [3:0] lo, input logic [15:0] e);
    rd(lo, e[7:0]);
    rd(lo + 4'h1, e[15:8]);
  endtask : rd16

  // every finished read is paired with the oldest expected byte
  always @(rd_cnt) begin
    if (hresetn === 1'b1) chk({8'h0, rd_byte}, {8'h0, exp_q.pop_front()});
  end

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    hresetn = 1'b0;
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    capture_irq_ack = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_STATUS, 8'h01);
    rd(REG_FLAGS, 8'h00);
    rd16(REG_CNT_LO, CNT_RST);
    rd16(REG_CAP_LO, CNT_RST);
    for (int n = 0; n < 4; n++) begin
      v = 16'($random(seed));
      foreach (lo_t[k]) begin
        wr16(lo_t[k], v);
        rd16(lo_t[k], v);
      end
    end
    wr16(REG_CMPA_LO, 16'h5a3c);
    wr(REG_CNT_HI, 8'h77);
    rd(REG_CMPA_HI, 8'h5a);
    rd(REG_CNT_HI, 8'h77);
    wr16(REG_CAP_LO, 16'habcd);
    rd16(REG_CAP_LO, 16'h0000);
    wr(REG_CTRL, 8'h08);
    wr16(REG_CAP_LO, 16'habcd);
    rd16(REG_CAP_LO, 16'habcd);
    // outputs are looked at one edge after the write has landed
    foreach (mode_t[k]) begin
      wr(REG_CTRL, {4'h0, mode_t[k]});
      wr16(REG_CNT_LO, ceil_t[k]);
      @(posedge hclk) chk(count_ceiling, 16'h1);
      if (k == 0 || k == 7) chk(count_full, 16'h1);
      wr16(REG_CNT_LO, ceil_t[k] - 16'h1);
      @(posedge hclk) chk(count_ceiling, 16'h0);
      if (k == 4) chk(wave_a, 16'h0);
    end
    // counter write lands even while counting, then two ticks wrap it through full
    wr(REG_CTRL, 8'h10);
    wr16(REG_CNT_LO, 16'hfffe);
    wr(REG_CTRL, 8'h00);
    rd16(REG_CNT_LO, 16'h0000);
    wr(REG_FLAGS, 8'h07);
    wr16(REG_CMPA_LO, 16'h0010);
    wr16(REG_CMPB_LO, 16'h0020);
    wr16(REG_CNT_LO, 16'h0000);
    @(posedge hclk) chk(count_floor, 16'h1);
    chk(wave_b, 16'h1);
    wr(REG_CTRL, 8'h10);
    repeat (50) @(posedge hclk);
    wr(REG_CTRL, 8'h00);
    @(posedge hclk) chk(compare_match_flags, 16'h3);
    chk(wave_b, 16'h0);
    wr(REG_FLAGS, 8'h01);
    @(posedge hclk) chk(compare_match_flags, 16'h2);
    wr16(REG_CNT_LO, 16'h1234);
    wr(REG_CTRL, 8'h60);
    @(posedge hclk) capture_input_pin <= 1'b1;
    @(posedge hclk) capture_input_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(capture_event_flag, 16'h0);
    capture_input_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(capture_event_flag, 16'h1);
    rd16(REG_CAP_LO, 16'h1234);
    capture_irq_ack <= 1'b1;
    @(posedge hclk) capture_irq_ack <= 1'b0;
    @(posedge hclk) chk(capture_event_flag, 16'h0);
    wr(REG_CTRL, 8'he0);
    wr16(REG_CNT_LO, 16'h0abc);
    // let the filtered level settle low first, else the rising edge is lost
    repeat (4) @(posedge hclk);
    comparator_out <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(capture_event_flag, 16'h1);
    rd16(REG_CAP_LO, 16'h0abc);
    wr(REG_FLAGS, 8'h04);
    @(posedge hclk) chk(capture_event_flag, 16'h0);
    // compare A as ceiling in a pwm mode keeps its old value until the ceiling
    wr(REG_CTRL, 8'h0f);
    wr16(REG_CNT_LO, 16'h0010);
    wr16(REG_CMPA_LO, 16'h0030);
    @(posedge hclk) chk(count_ceiling, 16'h1);
    rd16(REG_CMPA_LO, 16'h0030);
    chk(hresp, 16'h0);
    @(posedge hclk);
    tally_and_finish();
  end
endmodule : test_timer16_byte_access
